// *** verilog/dspm_pkg.sv ***
/*
 * Shared constants and types of the multiply-accumulate block: register
 * offsets, control field layouts, function and width codes, element counts
 * and the packed structs that carry configuration between modules.
 * Assumes a 32-bit register bus with one aligned word per register.
 */
package dspm_pkg;

	// Register byte offsets.
	localparam logic [7:0] DSPM_CTRL_OFS = 8'h00;
	localparam logic [7:0] DSPM_SEL_OFS = 8'h04;
	localparam logic [7:0] DSPM_STATUS_OFS = 8'h08;
	localparam logic [7:0] DSPM_CLEAR_OFS = 8'h0c;
	localparam logic [7:0] DSPM_ENABLE_OFS = 8'h10;
	localparam logic [7:0] DSPM_INFO_OFS = 8'h14;

	// Values after reset.
	localparam logic [7:0] DSPM_CTRL_RST = 8'h00;
	localparam logic [11:0] DSPM_SEL_RST = 12'h000;
	localparam logic [1:0] DSPM_ENABLE_RST = 2'h0;

	// Field positions in the info register.
	localparam int DSPM_INFO_CNT_LSB = 0;
	localparam int DSPM_INFO_BAD_BIT = 4;

	// Operand widths and datapath sizes.
	localparam int DSPM_W9 = 9;
	localparam int DSPM_W18 = 18;
	localparam int DSPM_W36 = 36;
	localparam int DSPM_OPW = 72;
	localparam int DSPM_LANES = 8;
	localparam int DSPM_ACCW = 72;
	localparam int DSPM_ACCS = 2;
	localparam int DSPM_RESW = 144;

	// Function element codes.
	localparam logic [1:0] DSPM_FN_PROD = 2'h0;
	localparam logic [1:0] DSPM_FN_PACC = 2'h1;
	localparam logic [1:0] DSPM_FN_PSD = 2'h2;
	localparam logic [1:0] DSPM_FN_PSDA = 2'h3;

	// Operand width codes; the fourth code is unsupported.
	localparam logic [1:0] DSPM_WC_9 = 2'h0;
	localparam logic [1:0] DSPM_WC_18 = 2'h1;
	localparam logic [1:0] DSPM_WC_36 = 2'h2;

	// Element instances per block, indexed by width 9, 18, 36.
	localparam logic [3:0] DSPM_N_PROD [3] = '{4'h8, 4'h4, 4'h1};
	localparam logic [3:0] DSPM_N_PACC [3] = '{4'h2, 4'h2, 4'h0};
	localparam logic [3:0] DSPM_N_PSD [3] = '{4'h4, 4'h2, 4'h0};
	localparam logic [3:0] DSPM_N_PSDA [3] = '{4'h2, 4'h1, 4'h0};

	// Block configuration, the low byte of the control register.
	typedef struct packed {
		logic chain_en;
		logic sub;
		logic shift_mode;
		logic sgn;
		logic [1:0] width;
		logic [1:0] func;
	} dspm_cfg_type;

	// Enable and clear source choice for one register stage.
	typedef struct packed {
		logic [1:0] rst_sel;
		logic [1:0] ce_sel;
	} dspm_sel_type;

	// Source choices of input, pipeline and output stages.
	typedef struct packed {
		dspm_sel_type out_sel;
		dspm_sel_type pipe_sel;
		dspm_sel_type in_sel;
	} dspm_sels_type;

endpackage

// *** verilog/dspm_stage.sv ***
/*
 * One register stage of the datapath with its own choice of clock enable
 * and clear from the four shared sources.
 * Assumes the source lines come from logic on the same clock.
 */
`timescale 1ns/1ps
module dspm_stage #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Source choice and sources.
	input wire dspm_pkg::dspm_sel_type sel,
	input wire logic [3:0] enable_source_set,
	input wire logic [3:0] clear_source_set,
	// Data.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic load,
	output logic clear
);
	import dspm_pkg::*;

	assign clear = ce & clear_source_set[sel.rst_sel];
	assign load = ce & enable_source_set[sel.ce_sel] & ~clear;

	// Clear beats enable so a stage can be flushed while held.
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			q <= '0;
		end else if (load) begin
			q <= d;
		end
	end

endmodule

// *** verilog/dspm_mac_top.sv ***
/*
 * Configurable multiply, multiply-accumulate and sum-of-products block with
 * an AXI4-Lite register slave, operand shift chain, cascade and an overflow
 * interrupt.
 * Assumes fabric logic on aclk drives operands and the source lines, and
 * pre-extends narrow operands to the selected width.
 */
// Overview of operation
// - four function elements at widths 9/18; only product at 36.
// - operands all signed or all unsigned.
// - one operand width for whole block.
// - element count per width and function.
// - all but product elements chain through cascade input and output.
// - operand register loads directly or shifts.
// - each stage picks enable and clear source.
// - accumulator rolls over and flags overflow.
// - overflow pulse lasts one cycle while ce is high, and holds while ce is low.
`timescale 1ns/1ps
module dspm_mac_top (
	// Clock, reset and clock enable.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite slave.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Operands and shift chain.
	input wire logic [dspm_pkg::DSPM_OPW-1:0] operand_a,
	input wire logic [dspm_pkg::DSPM_OPW-1:0] operand_b,
	input wire logic [dspm_pkg::DSPM_W36-1:0] shift_in_a,
	input wire logic [dspm_pkg::DSPM_W36-1:0] shift_in_b,
	output logic [dspm_pkg::DSPM_W36-1:0] shift_out_a,
	output logic [dspm_pkg::DSPM_W36-1:0] shift_out_b,
	// Register control sources.
	input wire logic [3:0] enable_source_set,
	input wire logic [3:0] clear_source_set,
	// Cascade.
	input wire logic [dspm_pkg::DSPM_ACCW-1:0] cascade_in,
	output logic [dspm_pkg::DSPM_ACCW-1:0] cascade_out,
	// Results and events.
	output logic [dspm_pkg::DSPM_RESW-1:0] result,
	output logic [dspm_pkg::DSPM_ACCS-1:0] overflow,
	output logic irq
);
	import dspm_pkg::*;

	localparam int PW = DSPM_LANES * DSPM_OPW;

	dspm_cfg_type cfg;
	dspm_sels_type sels;
	logic [DSPM_ACCS-1:0] status;
	logic [DSPM_ACCS-1:0] irq_enable;
	logic [2*DSPM_OPW-1:0] next_in, in_q;
	logic [PW-1:0] next_prod, prod_q;
	logic [DSPM_RESW-1:0] next_out;
	logic [DSPM_ACCS-1:0] next_ovf;
	logic in_load, pipe_load, out_load, out_clear;
	logic [DSPM_OPW-1:0] a_q, b_q;
	logic [3:0] elem_count;
	logic cfg_bad;

	// Byte-lane merge for partial register writes.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				r[8*k +: 8] = nw[8*k +: 8];
			end
		end
		return r;
	endfunction

	// Extends a lane to the accumulator width, by sign or by zeros.
	function automatic logic [DSPM_OPW-1:0] ext(input logic [35:0] v,
		input logic [1:0] wc, input logic sg);
		logic [DSPM_OPW-1:0] r;
		logic msb;
		r = {36'h0, v};
		case (wc)
			DSPM_WC_9: msb = v[DSPM_W9-1];
			DSPM_WC_18: msb = v[DSPM_W18-1];
			default: msb = v[DSPM_W36-1];
		endcase
		if (sg && msb) begin
			case (wc)
				DSPM_WC_9: r[DSPM_OPW-1:DSPM_W9] = '1;
				DSPM_WC_18: r[DSPM_OPW-1:DSPM_W18] = '1;
				default: r[DSPM_OPW-1:DSPM_W36] = '1;
			endcase
		end
		return r;
	endfunction

	// ---------------- AXI4-Lite slave ----------------
	logic aw_got, w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [31:0] ctrl_wr, sel_wr, enable_wr;

	// Address and data are taken in either order, one write at a time.
	assign s_axi_awready = ce & ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign wr_fire = ce & aw_got & w_got;

	// Held write data merged into each writable register by byte lane.
	assign ctrl_wr = merge({24'h0, cfg}, w_data, w_strb);
	assign sel_wr = merge({20'h0, sels}, w_data, w_strb);
	assign enable_wr = merge({30'h0, irq_enable}, w_data, w_strb);

	// Capture of write address and data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_got <= 1'b0;
			end
		end
	end

	// Write response; unmapped offsets answer with a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					DSPM_CTRL_OFS, DSPM_SEL_OFS, DSPM_CLEAR_OFS,
					DSPM_ENABLE_OFS: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= DSPM_CTRL_RST;
			sels <= DSPM_SEL_RST;
			irq_enable <= DSPM_ENABLE_RST;
		end else if (wr_fire) begin
			case (aw_addr)
				DSPM_CTRL_OFS: cfg <= ctrl_wr[7:0];
				DSPM_SEL_OFS: sels <= sel_wr[11:0];
				DSPM_ENABLE_OFS: irq_enable <= enable_wr[1:0];
				default: ;
			endcase
		end
	end

	// Sticky overflow status; a new event wins over a same-cycle clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
		end else if (ce) begin
			if (wr_fire && aw_addr == DSPM_CLEAR_OFS && w_strb[0]) begin
				status <= (status & ~w_data[1:0]) | next_ovf;
			end else begin
				status <= status | next_ovf;
			end
		end
	end

	assign irq = |(status & irq_enable);

	// Read data; reserved bits read as zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					DSPM_CTRL_OFS: s_axi_rdata <= {24'h0, cfg};
					DSPM_SEL_OFS: s_axi_rdata <= {20'h0, sels};
					DSPM_STATUS_OFS: s_axi_rdata <= {30'h0, status};
					DSPM_CLEAR_OFS: s_axi_rdata <= 32'h0;
					DSPM_ENABLE_OFS: s_axi_rdata <= {30'h0, irq_enable};
					DSPM_INFO_OFS: s_axi_rdata <= {27'h0, cfg_bad,
						elem_count};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------- Element capacity ----------------
	// instances per width.
	always_comb begin
		elem_count = 4'h0;
		if (cfg.width != 2'h3) begin
			case (cfg.func)
				DSPM_FN_PROD: elem_count = DSPM_N_PROD[cfg.width];
				DSPM_FN_PACC: elem_count = DSPM_N_PACC[cfg.width];
				DSPM_FN_PSD: elem_count = DSPM_N_PSD[cfg.width];
				default: elem_count = DSPM_N_PSDA[cfg.width];
			endcase
		end
	end
	assign cfg_bad = (elem_count == 4'h0);

	// ---------------- Input stage ----------------
	assign a_q = in_q[DSPM_OPW-1:0];
	assign b_q = in_q[2*DSPM_OPW-1:DSPM_OPW];

	always_comb begin
		next_in = {operand_b, operand_a};
		if (cfg.shift_mode) begin
			case (cfg.width)
				DSPM_WC_9: next_in = {b_q[62:0], shift_in_b[8:0],
					a_q[62:0], shift_in_a[8:0]};
				DSPM_WC_18: next_in = {b_q[53:0], shift_in_b[17:0],
					a_q[53:0], shift_in_a[17:0]};
				default: next_in = {36'h0, shift_in_b, 36'h0, shift_in_a};
			endcase
		end
	end

	// The top lane feeds the next block's shift chain.
	always_comb begin
		case (cfg.width)
			DSPM_WC_9: begin
				shift_out_a = {27'h0, a_q[71:63]};
				shift_out_b = {27'h0, b_q[71:63]};
			end
			DSPM_WC_18: begin
				shift_out_a = {18'h0, a_q[71:54]};
				shift_out_b = {18'h0, b_q[71:54]};
			end
			default: begin
				shift_out_a = a_q[35:0];
				shift_out_b = b_q[35:0];
			end
		endcase
	end

	dspm_stage #(.W(2*DSPM_OPW)) u_in (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.sel(sels.in_sel),
		.enable_source_set(enable_source_set),
		.clear_source_set(clear_source_set),
		.d(next_in),
		.q(in_q),
		.load(in_load),
		.clear()
	);

	// ---------------- Products ----------------
	// lane products per width.
	for (genvar i = 0; i < DSPM_LANES; i++) begin : g_lane
		logic [35:0] va, vb;
		always_comb begin
			va = {27'h0, a_q[DSPM_W9*i +: DSPM_W9]};
			vb = {27'h0, b_q[DSPM_W9*i +: DSPM_W9]};
			if (cfg.width == DSPM_WC_18) begin
				va = (i < 4) ? {18'h0, a_q[DSPM_W18*(i%4) +: DSPM_W18]} : 36'h0;
				vb = (i < 4) ? {18'h0, b_q[DSPM_W18*(i%4) +: DSPM_W18]} : 36'h0;
			end else if (cfg.width != DSPM_WC_9) begin
				va = (i == 0) ? a_q[35:0] : 36'h0;
				vb = (i == 0) ? b_q[35:0] : 36'h0;
			end
		end
		// Low product bits are right for both signed and unsigned.
		assign next_prod[DSPM_OPW*i +: DSPM_OPW] =
			ext(va, cfg.width, cfg.sgn) * ext(vb, cfg.width, cfg.sgn);
	end

	dspm_stage #(.W(PW)) u_pipe (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.sel(sels.pipe_sel),
		.enable_source_set(enable_source_set),
		.clear_source_set(clear_source_set),
		.d(next_prod),
		.q(prod_q),
		.load(pipe_load),
		.clear()
	);

	// ---------------- Sums, accumulation and output ----------------
	logic [DSPM_OPW-1:0] p [DSPM_LANES];
	logic [DSPM_OPW-1:0] s [4];
	logic [DSPM_ACCW-1:0] addend [DSPM_ACCS];
	logic [DSPM_ACCW-1:0] acc_old [DSPM_ACCS];
	logic [DSPM_ACCW:0] acc_new [DSPM_ACCS];
	logic [DSPM_ACCW-1:0] chain_add;
	logic accum;

	assign chain_add = cfg.chain_en ? cascade_in : '0;
	assign accum = (cfg.func == DSPM_FN_PACC) || (cfg.func == DSPM_FN_PSDA);

	// Pairwise sum or difference of neighbouring products.
	always_comb begin
		for (int k = 0; k < DSPM_LANES; k++) begin
			p[k] = prod_q[DSPM_OPW*k +: DSPM_OPW];
		end
		for (int k = 0; k < 4; k++) begin
			s[k] = cfg.sub ? p[2*k] - p[2*k+1] : p[2*k] + p[2*k+1];
		end
	end

	always_comb begin
		for (int e = 0; e < DSPM_ACCS; e++) begin
			acc_old[e] = result[DSPM_ACCW*e +: DSPM_ACCW];
			if (cfg.func == DSPM_FN_PACC) begin
				addend[e] = p[e];
			end else if (cfg.width == DSPM_WC_9) begin
				addend[e] = s[2*e] + s[2*e+1];
			end else begin
				addend[e] = s[e];
			end
			if (e == 0) begin
				addend[e] = addend[e] + chain_add;
			end
			acc_new[e] = {1'b0, acc_old[e]} + {1'b0, addend[e]};
			if (!accum || e >= elem_count) begin
				next_ovf[e] = 1'b0;
			end else if (cfg.sgn) begin
				next_ovf[e] = (acc_old[e][DSPM_ACCW-1] ==
					addend[e][DSPM_ACCW-1]) &&
					(acc_new[e][DSPM_ACCW-1] != acc_old[e][DSPM_ACCW-1]);
			end else begin
				next_ovf[e] = acc_new[e][DSPM_ACCW];
			end
			next_ovf[e] = next_ovf[e] & out_load;
		end
	end

	// Output packing; lanes above the element count stay zero.
	always_comb begin
		next_out = '0;
		case (cfg.func)
			DSPM_FN_PROD: begin
				for (int k = 0; k < DSPM_LANES; k++) begin
					if (k < elem_count) begin
						case (cfg.width)
							DSPM_WC_9: next_out[18*k +: 18] = p[k][17:0];
							DSPM_WC_18: next_out[36*(k%4) +: 36] = p[k][35:0];
							default: next_out[71:0] = p[0];
						endcase
					end
				end
			end
			DSPM_FN_PSD: begin
				for (int k = 0; k < 4; k++) begin
					if (k < elem_count) begin
						if (cfg.width == DSPM_WC_9) begin
							next_out[36*k +: 36] = s[k][35:0];
						end else begin
							next_out[72*(k%2) +: 72] = s[k];
						end
					end
				end
				next_out[71:0] = next_out[71:0] + chain_add;
			end
			default: begin
				for (int e = 0; e < DSPM_ACCS; e++) begin
					if (e < elem_count) begin
						next_out[DSPM_ACCW*e +: DSPM_ACCW] =
							acc_new[e][DSPM_ACCW-1:0];
					end
				end
			end
		endcase
	end

	dspm_stage #(.W(DSPM_RESW)) u_out (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.sel(sels.out_sel),
		.enable_source_set(enable_source_set),
		.clear_source_set(clear_source_set),
		.d(next_out),
		.q(result),
		.load(out_load),
		.clear(out_clear)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow <= '0;
		end else if (ce) begin
			overflow <= out_clear ? '0 : next_ovf;
		end
	end

	// Cascade output mirrors element zero of the registered result.
	assign cascade_out = result[DSPM_ACCW-1:0];

endmodule

// *** bench/dspm_mac_top_monitor.sv ***
/* Concurrent checks on the ports of the multiply-accumulate block.
   Assumes one clock, a synchronous low reset and ce held high. */
`timescale 1ns/1ps
module dspm_mac_top_monitor (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Results and events.
	input wire logic [dspm_pkg::DSPM_RESW-1:0] result,
	input wire logic [dspm_pkg::DSPM_ACCS-1:0] overflow,
	input wire logic irq
);
	import dspm_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Address and data taken together, then the answer two edges on.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data not on time");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_write_block: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken while answer pending");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("new read taken while data pending");
	a_reset_clean: assert property ($rose(aresetn)
		|-> result == '0 && overflow == '0 && !irq && !s_axi_bvalid)
		else $error("outputs not clear after reset");
	a_ovf_update: assert property (
		overflow[0] |-> $changed(result[DSPM_ACCW-1:0]))
		else $error("overflow pulse without accumulator update");
	a_ovf_single: assert property (
		overflow[0] ##1 !$changed(result[DSPM_ACCW-1:0]) |-> !overflow[0])
		else $error("overflow pulse longer than one update");
endmodule

// *** bench/dspm_fabric.sv ***
/* Fabric model that widens narrow 8-bit (or 32-bit) operands to the lane
   width of the block. Assumes the bench changes its inputs after an edge. */
`timescale 1ns/1ps
module dspm_fabric (
	// Narrow operands and the chosen format.
	input wire logic [63:0] raw_a,
	input wire logic [63:0] raw_b,
	input wire logic [1:0] wc,
	input wire logic sgn,
	// Operands at the lane width.
	output logic [dspm_pkg::DSPM_OPW-1:0] operand_a,
	output logic [dspm_pkg::DSPM_OPW-1:0] operand_b
);
	import dspm_pkg::*;
	// Unused lanes stay zero so stray bits never reach the block.
	function automatic logic [71:0] widen(input logic [63:0] r,
		input logic [1:0] w, input logic s);
		logic [71:0] v;
		v = '0;
		for (int i = 0; i < 8; i++) begin
			if (w == DSPM_WC_9)
				v[9*i+:9] = {s & r[8*i+7], r[8*i+:8]};
			else if (w == DSPM_WC_18 && i < 4)
				v[18*i+:18] = {{10{s & r[8*i+7]}}, r[8*i+:8]};
			else if (w == DSPM_WC_36 && i == 0)
				v[35:0] = {{4{s & r[31]}}, r[31:0]};
		end
		return v;
	endfunction
	// Widening is pure wiring in the fabric.
	always_comb begin
		operand_a = widen(raw_a, wc, sgn);
		operand_b = widen(raw_b, wc, sgn);
	end
endmodule

// *** bench/dspm_mac_top_test.sv ***
/* Self-checking bench of the multiply-accumulate block.
   Assumes the fabric model and the monitor are compiled before it. */
`timescale 1ns/1ps
module dspm_mac_top_test;
	import dspm_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] s_axi_awaddr = '0;
	logic [7:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, overflow;
	logic [31:0] s_axi_rdata;
	logic [35:0] shift_in_a = '0;
	logic [35:0] shift_in_b = '0;
	logic [35:0] shift_out_a, shift_out_b;
	logic [3:0] enable_source_set = 4'hf;
	logic [3:0] clear_source_set = 4'h0;
	logic [71:0] cascade_in = '0;
	logic [71:0] operand_a, operand_b, cascade_out;
	logic [143:0] result, x_pop;
	logic [63:0] raw_a = '0;
	logic [63:0] raw_b = '0;
	logic [1:0] wc = 2'h0;
	logic sgn = 1'b0;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [143:0] xq[$];
	event res_ev;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;

	dspm_mac_top u_dspm_mac_top (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.operand_a, .operand_b, .shift_in_a, .shift_in_b,
		.shift_out_a, .shift_out_b, .enable_source_set,
		.clear_source_set, .cascade_in, .cascade_out, .result,
		.overflow, .irq);
	dspm_fabric u_dspm_fabric (.raw_a, .raw_b, .wc, .sgn, .operand_a,
		.operand_b);

	// Clock of 4 ns period.
	always #2 aclk = ~aclk;

	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// A hang costs one error and ends the run.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic cmp_reg(input string nm, input logic [33:0] e,
		input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cmp_res(input logic [143:0] e, input logic [143:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD result exp %h got %h", e, g);
		end
	endtask

	// Handshakes are looked at mid-cycle, when inputs and outputs are still.
	always @(negedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			cmp_reg("bresp", {bq.pop_front(), 32'h0}, {s_axi_bresp, 32'h0});
		if (s_axi_rvalid && s_axi_rready)
			cmp_reg("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
	end
	// The cascade output must follow element zero of every checked result.
	always @(res_ev) begin
		x_pop = xq.pop_front();
		cmp_res(x_pop, result);
		cmp_res({72'h0, x_pop[71:0]}, {72'h0, cascade_out});
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic aw, w, b;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic ar, v;
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			v = s_axi_rvalid;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic chk_res(input logic [143:0] e);
		xq.push_back(e);
		@(negedge aclk);
		->res_ev;
		@(posedge aclk);
	endtask

	task automatic chk_irq(input logic e);
		@(negedge aclk);
		cmp_reg("irq", {33'h0, e}, {33'h0, irq});
		@(posedge aclk);
	endtask

	// Lane products packed the way the output register holds them.
	function automatic logic [143:0] prod(input logic [63:0] a,
		input logic [63:0] b, input logic [1:0] w, input logic s);
		logic [143:0] e;
		logic [63:0] x, y, p;
		e = '0;
		for (int k = 0; k < 8; k++) begin
			x = w[1] ? {{32{s & a[31]}}, a[31:0]} : {{56{s & a[8*k+7]}}, a[8*k+:8]};
			y = w[1] ? {{32{s & b[31]}}, b[31:0]} : {{56{s & b[8*k+7]}}, b[8*k+:8]};
			p = x * y;
			if (w == 2'h0)
				e[18*k+:18] = p[17:0];
			else if (w == 2'h1 && k < 4)
				e[36*k+:36] = p[35:0];
			else if (w == 2'h2 && k == 0)
				e[71:0] = {{8{s & p[63]}}, p};
		end
		return e;
	endfunction

	function automatic logic [3:0] cnt(input int f, input int w);
		case (f)
			0: return DSPM_N_PROD[w];
			1: return DSPM_N_PACC[w];
			2: return DSPM_N_PSD[w];
			default: return DSPM_N_PSDA[w];
		endcase
	endfunction

	initial begin
		logic [63:0] a, b;
		logic [143:0] e;
		logic [3:0] c;
		logic [33:0] so;
		int n;
		void'($urandom(32'h1e0e));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(DSPM_CTRL_OFS, 34'h0);
		rd(DSPM_SEL_OFS, 34'h0);
		rd(DSPM_ENABLE_OFS, 34'h0);
		rd(8'h40, {2'b10, 32'h0});
		wr(DSPM_STATUS_OFS, 32'h3, 2'b10);
		for (int w = 0; w < 3; w++) begin
			for (int f = 0; f < 4; f++) begin
				c = cnt(f, w);
				wr(DSPM_CTRL_OFS, {28'h0, w[1:0], f[1:0]}, 2'b00);
				rd(DSPM_INFO_OFS, {29'h0, c == 4'h0, c});
			end
		end
		for (int s = 0; s < 2; s++) begin
			for (int w = 0; w < 3; w++) begin
				wr(DSPM_CTRL_OFS, {27'h0, s[0], w[1:0], DSPM_FN_PROD}, 2'b00);
				wc <= w[1:0];
				sgn <= s[0];
				repeat (3) begin
					a = {$urandom(), $urandom()};
					b = {$urandom(), $urandom()};
					raw_a <= a;
					raw_b <= b;
					repeat (3) @(posedge aclk);
					e = prod(a, b, w[1:0], s[0]);
					chk_res(e);
				end
			end
		end
		// A low clock enable must hold every stage whatever the operands do.
		ce <= 1'b0;
		raw_a <= ~a;
		repeat (4) @(posedge aclk);
		chk_res(e);
		ce <= 1'b1;
		wr(DSPM_CTRL_OFS, 32'h20, 2'b00);
		wr(DSPM_SEL_OFS, 32'h1, 2'b00);
		for (int i = 1; i <= 8; i++) begin
			shift_in_a <= 36'(i);
			shift_in_b <= 36'h1;
			@(posedge aclk);
		end
		enable_source_set <= 4'hd;
		repeat (2) @(posedge aclk);
		e = '0;
		for (int k = 0; k < 8; k++)
			e[18*k+:18] = 18'(8 - k);
		chk_res(e);
		// The first value shifted in now sits in the top lane of both chains.
		@(negedge aclk);
		so = {shift_out_b[16:0], shift_out_a[16:0]};
		cmp_reg("shift_out", 34'h20001, so);
		@(posedge aclk);
		wr(DSPM_SEL_OFS, 32'hc01, 2'b00);
		clear_source_set <= 4'h8;
		@(posedge aclk);
		chk_res('0);
		wr(DSPM_SEL_OFS, 32'h0, 2'b00);
		enable_source_set <= 4'hf;
		raw_a <= '0;
		for (int s = 0; s < 2; s++) begin
			clear_source_set <= 4'h1;
			cascade_in <= s ? {1'b0, {71{1'b1}}} : '1;
			wr(DSPM_CTRL_OFS, {24'h0, 3'b100, s[0], DSPM_WC_9, DSPM_FN_PACC}, 2'b00);
			wr(DSPM_ENABLE_OFS, 32'h1, 2'b00);
			clear_source_set <= 4'h0;
			repeat (6) @(posedge aclk);
			n = 0;
			repeat (16) begin
				@(negedge aclk);
				if (overflow[0] === 1'b1)
					n++;
				@(posedge aclk);
			end
			cmp_reg("pulses", 34'(s ? 8 : 16), 34'(n));
			chk_irq(1'b1);
			rd(DSPM_STATUS_OFS, 34'h1);
			wr(DSPM_ENABLE_OFS, 32'h0, 2'b00);
			chk_irq(1'b0);
			clear_source_set <= 4'h1;
			wr(DSPM_CLEAR_OFS, 32'h1, 2'b00);
			rd(DSPM_STATUS_OFS, 34'h0);
		end
		end_sim();
	end
endmodule

bind dspm_mac_top dspm_mac_top_monitor u_dspm_mac_top_monitor (.aclk,
	.aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .result,
	.overflow, .irq);
